// ===== sim/asram_host_properties.sv
// checker of the host strobe timing, bound onto asram_host
// assumes the default one-cycle strobe and access parameters
module asram_props
  import asram_pkg::*;
(
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic REQ_VALID,
  input wire logic REQ_WRITE,
  input wire logic [ADDR_W-1:0] REQ_ADDR,
  input wire logic [DATA_W-1:0] REQ_WDATA,
  input wire logic REQ_READY,
  input wire logic RD_VALID,
  input wire logic [ADDR_W-1:0] MEM_ADDR,
  input wire logic MEM_CE_N,
  input wire logic MEM_WE_N,
  input wire logic MEM_OE_N,
  input wire logic [DATA_W-1:0] MEM_DQ_O,
  input wire logic MEM_DQ_OE
);
  timeunit 1ns;
  timeprecision 1ps;
  // ********
  // strobes
  // ********
  default clocking @(posedge MCLK);
  endclocking
  default disable iff (!RST_N);
  logic take;
  // request accepted this edge
  assign take = REQ_VALID && REQ_READY;
  read_launch_a: assert property (take && !REQ_WRITE |=> !MEM_CE_N && !MEM_OE_N
    && MEM_WE_N && MEM_ADDR == $past(REQ_ADDR)) else $error("read launch");
  write_launch_a: assert property (take && REQ_WRITE |=> !MEM_CE_N && !MEM_WE_N
    && MEM_OE_N && MEM_DQ_OE && MEM_DQ_O == $past(REQ_WDATA) && MEM_ADDR == $past(REQ_ADDR))
    else $error("write launch");
  write_pulse_a: assert property ($fell(MEM_WE_N) |=> MEM_WE_N && MEM_CE_N
    && $stable(MEM_ADDR)) else $error("write pulse");
  data_hold_a: assert property ($rose(MEM_WE_N) |-> MEM_DQ_OE && $stable(MEM_DQ_O))
    else $error("data hold");
  read_answer_a: assert property (take && !REQ_WRITE |-> ##2 RD_VALID ##1 !RD_VALID)
    else $error("read answer");
  no_fight_a: assert property (!MEM_OE_N |-> !MEM_DQ_OE && MEM_WE_N)
    else $error("bus fight");
  busy_span_a: assert property (take |=> !REQ_READY [*2] ##1 REQ_READY)
    else $error("busy span");
  deselect_a: assert property (MEM_CE_N |-> MEM_WE_N && MEM_OE_N)
    else $error("deselect");
endmodule : asram_props

bind asram_host asram_props u_props (.MCLK(MCLK), .RST_N(RST_N), .REQ_VALID(REQ_VALID),
  .REQ_WRITE(REQ_WRITE), .REQ_ADDR(REQ_ADDR), .REQ_WDATA(REQ_WDATA), .REQ_READY(REQ_READY),
  .RD_VALID(RD_VALID), .MEM_ADDR(MEM_ADDR), .MEM_CE_N(MEM_CE_N), .MEM_WE_N(MEM_WE_N),
  .MEM_OE_N(MEM_OE_N), .MEM_DQ_O(MEM_DQ_O), .MEM_DQ_OE(MEM_DQ_OE));

// ===== sim/asram_mem_model.sv
// behavioural 256K x 4 static memory on the far side of the host
// assumes the bench resolves the shared data wire and feeds it back
module asram_mem_model
  import asram_pkg::*;
(
  input wire logic clk,
  input wire logic [ADDR_W-1:0] word_address,
  input wire logic ce_n,
  input wire logic we_n,
  input wire logic oe_n,
  input wire logic [DATA_W-1:0] shared_data_bus,
  output logic [DATA_W-1:0] dq_drv,
  output logic dq_en
);
  timeunit 1ns;
  timeprecision 1ps;
  // full array, undefined until written, no refresh needed
  logic [DATA_W-1:0] mem_q [0:(1 << ADDR_W)-1];
  logic [DATA_W-1:0] junk_q = 4'h5;
  logic wr_end;
  // drive only in read mode; released pins churn so a stale word never passes
  assign dq_en = !ce_n && !oe_n && we_n;
  assign dq_drv = dq_en ? mem_q[word_address] : junk_q;
  // the earlier of the two rising strobes ends the overlap and lands the word
  assign wr_end = ce_n | we_n;
  always @(posedge wr_end) begin
    mem_q[word_address] <= shared_data_bus;
  end
  // released-bus churn, stepped on the bench clock
  always @(posedge clk) begin
    junk_q <= junk_q + 4'h3;
  end
endmodule : asram_mem_model

// ===== sim/tb_async_sram_256k_x4.sv
// self-checking bench: host controller against the behavioural memory
// assumes default strobe parameters and a 50 MHz clock
module tb_async_sram_256k_x4
  import asram_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0, rst_n = 1'b0, req_valid = 1'b0, req_write = 1'b0;
  logic rdy, rv, ce_n, we_n, oe_n, dq_oe, m_en;
  logic [ADDR_W-1:0] req_addr = 18'h00000, mem_addr;
  logic [DATA_W-1:0] req_wdata = 4'h0, rd_data, dq_o, m_drv, dq_w;
  logic [DATA_W-1:0] shadow [logic [ADDR_W-1:0]];
  int n_errors = 0, samples_checked = 0, cyc = 0;
  always #10 mclk = ~mclk;
  asram_host dut (.MCLK(mclk), .RST_N(rst_n), .REQ_VALID(req_valid), .REQ_WRITE(req_write),
    .REQ_ADDR(req_addr), .REQ_WDATA(req_wdata), .REQ_READY(rdy), .RD_VALID(rv), .RD_DATA(rd_data),
    .MEM_ADDR(mem_addr), .MEM_CE_N(ce_n), .MEM_WE_N(we_n), .MEM_OE_N(oe_n), .MEM_DQ_I(dq_w),
    .MEM_DQ_O(dq_o), .MEM_DQ_OE(dq_oe));
  asram_mem_model mem (.clk(mclk), .word_address(mem_addr), .ce_n(ce_n), .we_n(we_n),
    .oe_n(oe_n), .shared_data_bus(dq_w), .dq_drv(m_drv), .dq_en(m_en));
  // host wins the wire only while it drives; both at once garbles it
  assign dq_w = dq_oe ? (m_en ? 4'hX : dq_o) : m_drv;
  task automatic check(input logic [3:0] seen, input logic [3:0] exp, input string what);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : complete_run
  // address pool: low and high corners of the array
  function automatic logic [ADDR_W-1:0] pool(input int k);
    return k[0] ? {14'h3FFF, k[3:0]} : {14'h0000, k[3:0]};
  endfunction : pool
  // one request, held until taken, then wait for idle
  task automatic req(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    logic got;
    got = 1'b0;
    req_valid <= 1'b1;
    req_write <= w;
    req_addr <= a;
    req_wdata <= d;
    do @(posedge mclk); while (rdy !== 1'b1);
    req_valid <= 1'b0;
    req_addr <= 18'($urandom());
    do begin
      @(posedge mclk);
      if (rv === 1'b1) got = 1'b1;
      if (rv === 1'b1 && !w) check(rd_data, shadow[a], "read data");
      check({3'h0, dq_oe & m_en}, 4'h0, "bus fight");
    end while (rdy !== 1'b1);
    check({3'h0, got}, {3'h0, !w}, "read pulse");
    if (w) shadow[a] = d;
  endtask : req
  // hang guard, far above the expected 1336 cycles
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 4000) begin
      n_errors++;
      complete_run();
    end
  end
  initial begin
    void'($urandom(35));
    repeat (6) @(posedge mclk);
    check({ce_n, we_n, oe_n, dq_oe}, 4'hE, "reset pins");
    rst_n <= 1'b1;
    for (int i = 0; i < 16; i++) req(1'b1, pool(i), 4'($urandom()));
    for (int i = 0; i < 300; i++) req(1'($urandom()), pool(i % 7 * 3 % 16), 4'($urandom()));
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    check({ce_n, we_n, oe_n, dq_oe}, 4'hE, "mid reset pins");
    rst_n <= 1'b1;
    for (int i = 0; i < 16; i++) req(1'b0, pool(i), 4'h0);
    complete_run();
  end
endmodule : tb_async_sram_256k_x4

// ===== src/asram_host.sv
// host controller driving an asynchronous 256K x 4 static memory
// assumes memory pins sampled synchronously to MCLK; one request at a time
module asram_host
  import asram_pkg::*;
#(
  parameter int ACCESS_CYC = CYC_ACCESS,
  parameter int WP_CYC = CYC_WP,
  parameter int HIZ_CYC = CYC_HIZ
) (
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic REQ_VALID,
  input wire logic REQ_WRITE,
  input wire logic [ADDR_W-1:0] REQ_ADDR,
  input wire logic [DATA_W-1:0] REQ_WDATA,
  output logic REQ_READY,
  output logic RD_VALID,
  output logic [DATA_W-1:0] RD_DATA,
  output logic [ADDR_W-1:0] MEM_ADDR,
  output logic MEM_CE_N,
  output logic MEM_WE_N,
  output logic MEM_OE_N,
  input wire logic [DATA_W-1:0] MEM_DQ_I,
  output logic [DATA_W-1:0] MEM_DQ_O,
  output logic MEM_DQ_OE
);

  // ************************************************************
  // elaboration checks
  // ************************************************************
  if (ACCESS_CYC < 1 || ACCESS_CYC >= (1 << CNT_W) || WP_CYC < 1 ||
      WP_CYC >= (1 << CNT_W) || HIZ_CYC < 1 || HIZ_CYC >= (1 << CNT_W)) begin : g_chk
    $error("asram_host: cycle counts out of range");
  end

  // ************************************************************
  // timing checks against the slowest grade
  // ************************************************************
  // counts that leave a figure unmet are refused, since the memory would
  // answer wrongly with no sign of it on any pin
  if (ACCESS_CYC * CLK_PERIOD_NS < T_ACCESS_NS ||
      ACCESS_CYC * CLK_PERIOD_NS < T_OE_NS) begin : g_chk_access
    $error("asram_host: access count shorter than the access time");
  end
  if (WP_CYC * CLK_PERIOD_NS < T_WP_NS ||
      WP_CYC * CLK_PERIOD_NS < T_DW_NS) begin : g_chk_pulse
    $error("asram_host: write pulse shorter than the memory needs");
  end
  if (HIZ_CYC * CLK_PERIOD_NS < T_HIZ_NS) begin : g_chk_float
    $error("asram_host: turnaround shorter than the float time");
  end
  if ((WP_CYC + 2) * CLK_PERIOD_NS < T_CYCLE_NS ||
      (ACCESS_CYC + HIZ_CYC + 1) * CLK_PERIOD_NS < T_CYCLE_NS) begin : g_chk_cycle
    $error("asram_host: cycle shorter than the cycle minimum");
  end

  // ************************************************************
  // state
  // ************************************************************
  // one register per pin group; the pin struct keeps address and strobes together
  asram_state_t state_q, state_d;
  asram_pins_t pins_q, pins_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic [DATA_W-1:0] dq_o_q, dq_o_d;
  logic dq_oe_q, dq_oe_d;
  logic ready_q, ready_d;
  logic rd_valid_q, rd_valid_d;
  logic [DATA_W-1:0] rd_data_q, rd_data_d;

  // sequence at the default counts, one step per clock edge:
  //   read:  take | pins set, ce and oe low | data sampled, strobes high | ready
  //   write: take | pins set, ce and we low, data out | we and ce high | data off, ready
  // a read costs three edges from take to the next take, and so does a write
  // the address register only changes on a take, so it stands through the whole
  // cycle and past the end of the write: zero recovery is never leaned on
  // ready drops on the take itself, so a held request cannot be taken twice
  // the read data is sampled at the last edge of the access count; the pins
  // are registered, so the memory sees a full clock period of access time
  // trade-off: slowest grade figures give whole cycles here, which wastes
  // time on fast parts but lets any grade sit on the board unchanged

  // next-state logic for the whole transfer sequencer
  always_comb begin
    state_d = state_q;
    pins_d = pins_q;
    cnt_d = cnt_q;
    dq_o_d = dq_o_q;
    dq_oe_d = dq_oe_q;
    ready_d = ready_q;
    rd_valid_d = 1'b0;
    rd_data_d = rd_data_q;
    case (state_q)
      AS_IDLE: begin
        if (REQ_VALID && ready_q) begin
          ready_d = 1'b0;
          pins_d.word_address = REQ_ADDR;
          pins_d.ce_n = 1'b0;
          if (REQ_WRITE) begin
            // address, strobes and data all change together: zero setup allowed
            pins_d.we_n = 1'b0;
            pins_d.oe_n = 1'b1; // keeps the shorter pulse figure valid
            dq_o_d = REQ_WDATA;
            dq_oe_d = 1'b1; // memory floats under we low
            cnt_d = CNT_W'(WP_CYC);
            state_d = AS_WRITE;
          end else begin
            pins_d.we_n = 1'b1;
            pins_d.oe_n = 1'b0;
            dq_oe_d = 1'b0;
            cnt_d = CNT_W'(ACCESS_CYC);
            state_d = AS_READ;
          end
        end
      end
      AS_READ: begin
        // wait out address, enable and output enable access
        if (cnt_q > CNT_W'(1)) begin
          cnt_d = cnt_q - CNT_W'(1);
        end else begin
          // the sample lands in a flop: the bus wire is never used unregistered
          rd_data_d = MEM_DQ_I;
          rd_valid_d = 1'b1;
          pins_d.ce_n = 1'b1;
          pins_d.oe_n = 1'b1;
          cnt_d = CNT_W'(HIZ_CYC);
          state_d = AS_TURN;
        end
      end
      AS_WRITE: begin
        // strobe low for at least the pulse width, data set up well before end
        if (cnt_q > CNT_W'(1)) begin
          cnt_d = cnt_q - CNT_W'(1);
        end else begin
          pins_d.we_n = 1'b1; // earlier rising edge ends the write
          pins_d.ce_n = 1'b1;
          state_d = AS_WEND;
        end
      end
      AS_WEND: begin
        // data released one cycle after the strobe: hold is zero, this is margin
        // the memory was deselected a cycle ago, so only the host holds the wire
        dq_oe_d = 1'b0;
        ready_d = 1'b1;
        state_d = AS_IDLE;
      end
      AS_TURN: begin
        // memory bus must float before anyone else may drive it
        if (cnt_q > CNT_W'(1)) begin
          cnt_d = cnt_q - CNT_W'(1);
        end else begin
          ready_d = 1'b1;
          state_d = AS_IDLE;
        end
      end
      default: begin
        state_d = AS_IDLE;
        pins_d = '{ADDR_RST, 1'b1, 1'b1, 1'b1};
        dq_oe_d = 1'b0;
        ready_d = 1'b1;
      end
    endcase
  end

  // registers only; the synchronous reset parks the memory deselected
  // so a board coming out of reset never sees a stray write
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      state_q <= AS_IDLE;
      pins_q <= '{ADDR_RST, 1'b1, 1'b1, 1'b1}; // deselected
      cnt_q <= '0;
      dq_o_q <= DATA_RST;
      dq_oe_q <= 1'b0;
      ready_q <= 1'b1;
      rd_valid_q <= 1'b0;
      rd_data_q <= DATA_RST;
    end else begin
      state_q <= state_d;
      pins_q <= pins_d;
      cnt_q <= cnt_d;
      dq_o_q <= dq_o_d;
      dq_oe_q <= dq_oe_d;
      ready_q <= ready_d;
      rd_valid_q <= rd_valid_d;
      rd_data_q <= rd_data_d;
    end
  end

  // ************************************************************
  // outputs, all from flops
  // ************************************************************
  // strobes come straight from flops, so no decode glitch reaches the memory
  assign REQ_READY = ready_q;
  assign RD_VALID = rd_valid_q;
  assign RD_DATA = rd_data_q;
  assign MEM_ADDR = pins_q.word_address;
  assign MEM_CE_N = pins_q.ce_n;
  assign MEM_WE_N = pins_q.we_n;
  assign MEM_OE_N = pins_q.oe_n;
  assign MEM_DQ_O = dq_o_q;
  assign MEM_DQ_OE = dq_oe_q;

endmodule : asram_host

// ===== src/asram_pkg.sv
// package for the asynchronous sram host controller
// assumes a 50 MHz system clock and one memory of 256K words of 4 bits
package asram_pkg;

  // ************************************************************
  // geometry
  // ************************************************************
  localparam int ADDR_W = 18;
  localparam int DATA_W = 4;

  // ************************************************************
  // timing, slowest grade figures in ns
  // ************************************************************
  localparam int CLK_PERIOD_NS = 20;
  localparam int T_CYCLE_NS = 15;    // read and write cycle minimum
  localparam int T_ACCESS_NS = 15;   // address and enable access maximum
  localparam int T_OE_NS = 7;        // output enable access maximum
  localparam int T_HIZ_NS = 7;       // enable or output enable high to high-z
  localparam int T_WP_NS = 12;       // write pulse minimum
  localparam int T_DW_NS = 7;        // data valid to end of write
  // least times round up, none below one cycle
  localparam int CYC_ACCESS = ((T_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS) < 1 ? 1 :
                              ((T_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int CYC_WP = ((T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS) < 1 ? 1 :
                          ((T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int CYC_HIZ = ((T_HIZ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS) < 1 ? 1 :
                           ((T_HIZ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int CNT_W = 4;

  // ************************************************************
  // reset values and types
  // ************************************************************
  localparam logic [ADDR_W-1:0] ADDR_RST = 18'h00000;
  localparam logic [DATA_W-1:0] DATA_RST = 4'h0;

  typedef enum logic [4:0] {
    AS_IDLE  = 5'b00001,
    AS_READ  = 5'b00010,
    AS_WRITE = 5'b00100,
    AS_WEND  = 5'b01000,
    AS_TURN  = 5'b10000
  } asram_state_t;

  // pins toward the memory
  typedef struct packed {
    logic [ADDR_W-1:0] word_address;
    logic ce_n;
    logic we_n;
    logic oe_n;
  } asram_pins_t;

endpackage : asram_pkg
